// ===== common/twdl_pkg.sv
// package of constants and types for the two-wire debug link.
// assumes a 200 MHz mclk on both ends of the link.
package twdl_pkg;

	// ==========================================================
	// packet layout
	localparam int DATA_BITS = 8;
	localparam int PAR_IDX   = 8;              // parity bit position in packet
	localparam int ACK_IDX   = 9;              // acknowledge bit position
	localparam int PKT_BITS  = 10;

	// ==========================================================
	// timing
	localparam int MCLK_NS        = 5;
	localparam int LINK_HALF_NS   = 250;       // half period of the link clock
	localparam int HALF_CYC       = (LINK_HALF_NS + MCLK_NS - 1) / MCLK_NS;
	localparam int ENTRY_HOLD_NS  = 2000;      // entry levels held after reset
	localparam int ENTRY_HOLD_CYC = (ENTRY_HOLD_NS + MCLK_NS - 1) / MCLK_NS;
	localparam int ENTRY_SAMPLE_CYC = 16;      // device looks at the lines here
	localparam int CNT_W          = 9;

	// ==========================================================
	// power-on entry levels and reset values
	localparam logic ENTRY_CLK_LVL  = 1'b0;
	localparam logic ENTRY_DATA_LVL = 1'b1;
	localparam logic [7:0] BYTE_RST = 8'h00;

	// ==========================================================
	// host command port operations
	typedef enum logic [1:0] {
		TWDL_OP_WRITE = 2'b00,
		TWDL_OP_READ  = 2'b01,
		TWDL_OP_STOP  = 2'b10
	} twdl_op_t;

endpackage

// ===== common/twdl_if.sv
// the two open-drain link lines with a modport for each party.
// each party pulls a line low while its output enable and its output value are both low.
interface twdl_if;
	logic hostClkOut;
	logic hostClkOeN;
	logic hostDataOut;
	logic hostDataOeN;
	logic devClkOut;
	logic devClkOeN;
	logic devDataOut;
	logic devDataOeN;
	logic debugSerialClock;
	logic debugSerialData;

	// wired-and of both parties, pull-up gives the high level
	assign debugSerialClock = (hostClkOeN | hostClkOut) & (devClkOeN | devClkOut);
	assign debugSerialData  = (hostDataOeN | hostDataOut) & (devDataOeN | devDataOut);

	modport host (
		output hostClkOut, hostClkOeN, hostDataOut, hostDataOeN,
		input  debugSerialClock, debugSerialData
	);
	modport dev (
		output devClkOut, devClkOeN, devDataOut, devDataOeN,
		input  debugSerialClock, debugSerialData
	);
endinterface

// ===== rtl/twdl_sync.sv
// two flip-flop synchroniser for the link lines.
// assumes asynchronous inputs and a reset level of high (idle lines).
module twdl_sync #(
	parameter int W = 2
) (
	input  wire logic         mclk,
	input  wire logic         rst,
	input  wire logic [W-1:0] async,
	output logic      [W-1:0] synced
);
	logic [W-1:0] meta_reg;

	// ==========================================================
	// first stage feeds only the second
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			meta_reg <= '1;
			synced   <= '1;
		end else begin
			meta_reg <= async;
			synced   <= meta_reg;
		end
	end
endmodule // twdl_sync

// ===== rtl/twdl_device.sv
// device end of the two-wire debug link: entry, packets, wait state.
// assumes the link lines come through twdl_if and mclk runs at 200 MHz.
// Operation
// - debug entry only at power-on levels
// - half-duplex, host clock, one data line
// - packet: eight data, parity, acknowledge
// - transmitter makes parity even
// - receiver acks low, high on error
// - ack high at tenth clock fails packet
// - host stops and resends failed command (twdl_host stops the command but does not resend)
// - start opens, stop closes a command
// - start: data falls, clock high
// - stop: data rises, clock high
// - wait state after stop while processing
// - data changes only while clock low
// - device stretches clock; host waits high
// - both lines open-drain wired-and
// - drive data on read, input on write
// - debug wins over shared pin functions
module twdl_device
	import twdl_pkg::*;
(
	twdl_if.dev         link,
	input  wire logic       mclk,
	input  wire logic       rst,
	input  wire logic       cmdDone,
	input  wire logic       txLoad,
	input  wire logic [7:0] txByte,
	input  wire logic       portClkOut,
	input  wire logic       portClkOeN,
	input  wire logic       portDataOut,
	input  wire logic       portDataOeN,
	output logic            debugMode,
	output logic            cmdStart,
	output logic            cmdEnd,
	output logic [7:0]      rxByte,
	output logic            rxValid,
	output logic            rxErr,
	output logic            txErr,
	output logic            txBusy
);
	typedef enum logic [1:0] {
		ST_OFF   = 2'b00,
		ST_READY = 2'b01,
		ST_XFER  = 2'b10,
		ST_WAIT  = 2'b11
	} twdl_dev_st_t;

	twdl_dev_st_t state_reg;
	logic [1:0]   lineS;
	logic         clkS;
	logic         dataS;
	logic         clkP_reg;
	logic         dataP_reg;
	logic         clkRise;
	logic         clkFall;
	logic         startEv;
	logic         stopEv;
	logic         inXfer;
	logic [CNT_W-1:0] entryCnt_reg;
	logic         entryMatch;
	logic         entryTime;
	logic [3:0]   bitCnt_reg;
	logic         txMode_reg;
	logic         txPend_reg;
	logic [7:0]   txHold_reg;
	logic [7:0]   txSh_reg;
	logic [7:0]   rxSh_reg;
	logic         parOk_reg;
	logic         dataDrv_reg;
	logic         pktBegin;
	logic [2:0]   txIdx;

	// ==========================================================
	// line sampling and condition detection
	twdl_sync #(.W(2)) u_sync (
		.mclk   (mclk),
		.rst    (rst),
		.async  ({link.debugSerialClock, link.debugSerialData}),
		.synced (lineS)
	);
	assign clkS  = lineS[1];
	assign dataS = lineS[0];

	// previous synchronised levels for edge finding
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			clkP_reg  <= 1'b1;
			dataP_reg <= 1'b1;
		end else begin
			clkP_reg  <= clkS;
			dataP_reg <= dataS;
		end
	end

	// a data change with clock high is only ever start or stop
	assign clkRise = clkS & ~clkP_reg;
	assign clkFall = ~clkS & clkP_reg;
	assign startEv = clkS & clkP_reg & dataP_reg & ~dataS;
	assign stopEv  = clkS & clkP_reg & ~dataP_reg & dataS;
	assign inXfer  = (state_reg == ST_XFER);
	assign pktBegin = clkFall & inXfer & ((bitCnt_reg == 4'h0) | (bitCnt_reg == 4'ha));
	assign txIdx   = 3'(7 - int'(bitCnt_reg));

	// ==========================================================
	// power-on entry: lines looked at every cycle from ENTRY_SAMPLE_CYC on while the device is still off
	assign entryTime  = (entryCnt_reg == CNT_W'(ENTRY_SAMPLE_CYC));
	assign entryMatch = (clkS == ENTRY_CLK_LVL) & (dataS == ENTRY_DATA_LVL);

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			entryCnt_reg <= '0;
		end else if (!entryTime) begin
			entryCnt_reg <= entryCnt_reg + 1'b1;
		end
	end

	// ==========================================================
	// command state: off, ready, transfer, wait
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			state_reg <= ST_OFF;
		end else begin
			case (state_reg)
				ST_OFF: begin
					if (entryTime && entryMatch) begin
						state_reg <= ST_READY;
					end
				end
				ST_READY: begin
					if (startEv) begin
						state_reg <= ST_XFER;
					end
				end
				ST_XFER: begin
					if (stopEv) begin
						state_reg <= ST_WAIT;
					end
				end
				ST_WAIT: begin
					if (cmdDone) begin
						state_reg <= ST_READY;
					end
				end
				default: begin
					state_reg <= ST_OFF;
				end
			endcase
		end
	end

	// ==========================================================
	// bit counter and packet direction
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			bitCnt_reg <= 4'h0;
			txMode_reg <= 1'b0;
		end else if (startEv) begin
			bitCnt_reg <= 4'h0;
			txMode_reg <= 1'b0;
		end else if (pktBegin) begin
			bitCnt_reg <= 4'h0;
			txMode_reg <= txPend_reg;
		end else if (clkRise && inXfer && bitCnt_reg < 4'(PKT_BITS)) begin
			bitCnt_reg <= bitCnt_reg + 4'h1;
		end
	end

	// ==========================================================
	// receive shifter and parity check
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			rxSh_reg  <= BYTE_RST;
			parOk_reg <= 1'b0;
		end else if (clkRise && inXfer && !txMode_reg) begin
			if (bitCnt_reg < 4'(DATA_BITS)) begin
				rxSh_reg <= {rxSh_reg[6:0], dataS};
			end else if (bitCnt_reg == 4'(PAR_IDX)) begin
				parOk_reg <= ~(^{rxSh_reg, dataS});
			end
		end
	end

	// ==========================================================
	// transmit byte waiting for the next packet
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			txPend_reg <= 1'b0;
			txHold_reg <= BYTE_RST;
		end else if (txLoad) begin
			txPend_reg <= 1'b1;                               // load wins over take
			txHold_reg <= txByte;
		end else if (pktBegin) begin
			txPend_reg <= 1'b0;
		end
	end
	assign txBusy = txPend_reg;

	// ==========================================================
	// data line drive, set just after a clock fall, cleared at a start and outside a transfer
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			txSh_reg    <= BYTE_RST;
			dataDrv_reg <= 1'b0;
		end else if (startEv || !inXfer) begin
			dataDrv_reg <= 1'b0;
		end else if (pktBegin) begin
			txSh_reg    <= txHold_reg;
			dataDrv_reg <= txPend_reg & ~txHold_reg[7];
		end else if (clkFall) begin
			if (txMode_reg) begin
				if (bitCnt_reg < 4'(DATA_BITS)) begin
					dataDrv_reg <= ~txSh_reg[txIdx];
				end else if (bitCnt_reg == 4'(PAR_IDX)) begin
					dataDrv_reg <= ~(^txSh_reg);
				end else begin
					dataDrv_reg <= 1'b0;                      // host acks
				end
			end else if (bitCnt_reg == 4'(ACK_IDX)) begin
				dataDrv_reg <= parOk_reg;
			end else begin
				dataDrv_reg <= 1'b0;
			end
		end
	end

	// ==========================================================
	// user-side pulses and received byte
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			rxByte   <= BYTE_RST;
			rxValid  <= 1'b0;
			rxErr    <= 1'b0;
			txErr    <= 1'b0;
			cmdStart <= 1'b0;
			cmdEnd   <= 1'b0;
		end else begin
			rxValid  <= 1'b0;
			rxErr    <= 1'b0;
			txErr    <= 1'b0;
			cmdStart <= startEv & (state_reg == ST_READY);
			cmdEnd   <= stopEv & inXfer;
			if (clkFall && inXfer && !txMode_reg && bitCnt_reg == 4'(ACK_IDX)) begin
				rxByte  <= rxSh_reg;
				rxValid <= parOk_reg;
				rxErr   <= ~parOk_reg;
			end
			if (clkRise && inXfer && txMode_reg && bitCnt_reg == 4'(ACK_IDX)) begin
				txErr <= dataS;
			end
		end
	end

	// ==========================================================
	// pins: open-drain pull-downs, debug ahead of the shared port
	assign debugMode       = (state_reg != ST_OFF);
	assign link.devClkOut  = debugMode ? 1'b0 : portClkOut;
	assign link.devClkOeN  = debugMode ? (state_reg != ST_WAIT) : portClkOeN;
	assign link.devDataOut = debugMode ? 1'b0 : portDataOut;
	assign link.devDataOeN = debugMode ? ~dataDrv_reg : portDataOeN;

endmodule // twdl_device

// ===== rtl/twdl_host.sv
// host end of the two-wire debug link: makes the clock and frames.
// assumes a user sequencer that issues write, read and stop operations.
module twdl_host
	import twdl_pkg::*;
(
	twdl_if.host        link,
	input  wire logic       mclk,
	input  wire logic       rst,
	input  wire logic       opValid,
	input  wire twdl_op_t   opKind,
	input  wire logic [7:0] opData,
	output logic            opReady,
	output logic [7:0]      rdData,
	output logic            rdValid,
	output logic            ackErr,
	output logic            inCmd
);
	typedef enum logic [3:0] {
		HS_ENTRY = 4'b0000,
		HS_IDLE  = 4'b0001,
		HS_START = 4'b0010,
		HS_GAP   = 4'b0011,
		HS_LOW   = 4'b0100,
		HS_HIGH  = 4'b0101,
		HS_STOPA = 4'b0110,
		HS_STOPB = 4'b0111,
		HS_STOPC = 4'b1000
	} twdl_host_st_t;

	twdl_host_st_t state_reg;
	logic [1:0]    lineS;
	logic          clkS;
	logic          dataS;
	logic [CNT_W-1:0] cnt_reg;
	logic [3:0]    bit_reg;
	logic          rd_reg;
	logic [7:0]    sh_reg;
	logic          par_reg;
	logic          clkDrv_reg;
	logic          dataDrv_reg;
	logic          halfDone;

	twdl_sync #(.W(2)) u_sync (
		.mclk   (mclk),
		.rst    (rst),
		.async  ({link.debugSerialClock, link.debugSerialData}),
		.synced (lineS)
	);
	assign clkS     = lineS[1];
	assign dataS    = lineS[0];
	assign halfDone = (cnt_reg == CNT_W'(HALF_CYC - 1));
	// bytes are taken only in the gap; in idle an op just opens the frame
	assign opReady  = (state_reg == HS_GAP);
	assign inCmd    = (state_reg != HS_IDLE) & (state_reg != HS_ENTRY);

	// ==========================================================
	// sequencer: entry levels, start, bits, stop
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			state_reg   <= HS_ENTRY;
			cnt_reg     <= '0;
			bit_reg     <= 4'h0;
			rd_reg      <= 1'b0;
			sh_reg      <= BYTE_RST;
			par_reg     <= 1'b0;
			clkDrv_reg  <= ~ENTRY_CLK_LVL;   // power-on entry levels
			dataDrv_reg <= ~ENTRY_DATA_LVL;
			rdData      <= BYTE_RST;
			rdValid     <= 1'b0;
			ackErr      <= 1'b0;
		end else begin
			rdValid <= 1'b0;
			ackErr  <= 1'b0;
			cnt_reg <= cnt_reg + 1'b1;
			case (state_reg)
				HS_ENTRY: begin
					if (cnt_reg == CNT_W'(ENTRY_HOLD_CYC - 1)) begin
						clkDrv_reg  <= 1'b0;
						dataDrv_reg <= 1'b0;
						state_reg   <= HS_IDLE;
					end
				end
				HS_IDLE: begin
					cnt_reg <= '0;
					// first op stays pending until the gap so its byte is not lost
					if (opValid && clkS && opKind != TWDL_OP_STOP) begin
						dataDrv_reg <= 1'b1;          // start: data falls, clock high
						state_reg   <= HS_START;
					end
				end
				HS_START: begin
					if (halfDone) begin
						clkDrv_reg <= 1'b1;
						state_reg  <= HS_GAP;
					end
				end
				HS_GAP: begin
					cnt_reg <= '0;
					if (opValid && opKind == TWDL_OP_STOP) begin
						dataDrv_reg <= 1'b1;
						state_reg   <= HS_STOPA;
					end else if (opValid) begin
						rd_reg    <= (opKind == TWDL_OP_READ);
						sh_reg    <= opData;
						par_reg   <= ^opData;        // even count of ones
						bit_reg   <= 4'h0;
						state_reg <= HS_LOW;
					end
				end
				HS_LOW: begin
					// data moves two cycles after the clock went low
					if (cnt_reg == CNT_W'(1)) begin
						if (bit_reg < 4'(DATA_BITS)) begin
							dataDrv_reg <= ~rd_reg & ~sh_reg[7];
						end else if (bit_reg == 4'(PAR_IDX)) begin
							dataDrv_reg <= ~rd_reg & ~par_reg;
						end else begin
							dataDrv_reg <= rd_reg & ~par_reg;   // read ack
						end
					end
					if (halfDone) begin
						clkDrv_reg <= 1'b0;
						cnt_reg    <= '0;
						state_reg  <= HS_HIGH;
					end
				end
				HS_HIGH: begin
					if (!clkS) begin
						cnt_reg <= '0;                // device stretching
					end else if (halfDone) begin
						cnt_reg    <= '0;
						clkDrv_reg <= 1'b1;
						bit_reg    <= bit_reg + 4'h1;
						state_reg  <= HS_LOW;
						if (bit_reg < 4'(DATA_BITS)) begin
							sh_reg <= {sh_reg[6:0], rd_reg ? dataS : sh_reg[7]};
						end else if (bit_reg == 4'(PAR_IDX)) begin
							par_reg <= rd_reg ? ^{sh_reg, dataS} : par_reg;
						end else begin
							rdData  <= sh_reg;
							rdValid <= rd_reg & ~par_reg;
							ackErr  <= rd_reg ? par_reg : dataS;
							dataDrv_reg <= 1'b0;
							state_reg <= HS_GAP;
							if (rd_reg ? par_reg : dataS) begin
								dataDrv_reg <= 1'b1;  // failed packet: close command
								state_reg   <= HS_STOPA;
							end
						end
					end
				end
				HS_STOPA: begin
					if (halfDone) begin
						clkDrv_reg <= 1'b0;
						cnt_reg    <= '0;
						state_reg  <= HS_STOPB;
					end
				end
				HS_STOPB: begin
					if (!clkS) begin
						cnt_reg <= '0;
					end else if (halfDone) begin
						dataDrv_reg <= 1'b0;          // stop: data rises, clock high
						cnt_reg     <= '0;
						state_reg   <= HS_STOPC;
					end
				end
				HS_STOPC: begin
					if (halfDone) begin
						state_reg <= HS_IDLE;
					end
				end
				default: begin
					state_reg <= HS_IDLE;
				end
			endcase
		end
	end

	// ==========================================================
	// open-drain pins
	assign link.hostClkOut  = 1'b0;
	assign link.hostClkOeN  = ~clkDrv_reg;
	assign link.hostDataOut = 1'b0;
	assign link.hostDataOeN = ~dataDrv_reg;

endmodule // twdl_host

// ===== bench/twdl_props.sv
// checker of the open-drain link lines between the host and device ends.
// assumes one mclk and rst for both ends and a device that is in debug mode.
module twdl_props
	import twdl_pkg::*;
(
	input wire logic mclk,
	input wire logic rst,
	input wire logic hostClkOut,
	input wire logic hostClkOeN,
	input wire logic hostDataOut,
	input wire logic hostDataOeN,
	input wire logic devClkOut,
	input wire logic devClkOeN,
	input wire logic devDataOut,
	input wire logic devDataOeN,
	input wire logic debugSerialClock,
	input wire logic debugSerialData
);
	default clocking @(posedge mclk); endclocking
	default disable iff (rst);

	// ==========================================================
	// framing events on the wire
	sequence s_start; $fell(hostDataOeN) && debugSerialClock; endsequence
	sequence s_stop; $rose(hostDataOeN) && debugSerialClock; endsequence
	sequence s_clkRise; $rose(debugSerialClock); endsequence

	// ==========================================================
	// line rules
	a_host_pins_low: assert property (!hostClkOut && !hostDataOut)
		else $error("host pin value not low");
	a_start_clock_high: assert property (s_start |=> debugSerialClock [*8])
		else $error("clock dropped right after start");
	a_stop_clock_high: assert property (s_stop |-> $past(debugSerialClock, 8))
		else $error("stop without clock high before it");
	a_stop_then_wait: assert property (s_stop |-> ##[1:8] !devClkOeN)
		else $error("device did not hold clock after stop");
	a_data_hold_high: assert property (s_clkRise |-> $stable(debugSerialData) [*8])
		else $error("data moved while clock high");
	a_high_phase_min: assert property (s_clkRise |-> hostClkOeN [*8])
		else $error("clock high phase too short");
	a_dev_change_low: assert property ($changed(devDataOeN) |-> !debugSerialClock)
		else $error("device moved data while clock high");
	a_stretch_wait: assert property (hostClkOeN && !debugSerialClock
		|=> hostClkOeN && $stable(hostDataOeN))
		else $error("host advanced while clock held low");
endmodule // twdl_props

// ===== bench/two_wire_debug_link_tb.sv
// self-checking bench: host and device ends face each other on one link,
// a second device sits on a link that the bench drives bit by bit.
module two_wire_debug_link_tb
	import twdl_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;

	// ==========================================================
	// signals
	logic       mclk = 1'b0, rst = 1'b1, rndOn = 1'b0;
	logic       opValid = 1'b0, cmdDone = 1'b0, txLoad = 1'b0, cmdDone2 = 1'b0, txLoad2 = 1'b0;
	twdl_op_t   opKind = TWDL_OP_WRITE;
	logic [7:0] opData = 8'h00, txByte = 8'h00, txByte2 = 8'h00, rdData, rxByte, d;
	logic       portClkOut = 1'b1, portClkOeN = 1'b1, portDataOut = 1'b1, portDataOeN = 1'b1;
	logic       opReady, rdValid, ackErr, inCmd, debugMode, cmdStart, cmdEnd;
	logic       rxValid, rxErr, txErr, txBusy, debugMode2, rxErr2, txErr2;
	logic [9:0] bbRx;
	logic [7:0] rxQ[$];
	logic [7:0] wb[4];
	int         mismatches = 0, checked = 0, nRx = 0, nAck = 0, nRd = 0, nSt = 0, nEnd = 0;
	int         nTxErr = 0, nRxErr2 = 0, nTxErr2 = 0;

	twdl_if link();
	twdl_if link2();
	twdl_host twdl_host_inst(.link(link.host), .mclk(mclk), .rst(rst), .opValid(opValid),
		.opKind(opKind), .opData(opData), .opReady(opReady), .rdData(rdData),
		.rdValid(rdValid), .ackErr(ackErr), .inCmd(inCmd));
	twdl_device twdl_device_inst(.link(link.dev), .mclk(mclk), .rst(rst), .cmdDone(cmdDone),
		.txLoad(txLoad), .txByte(txByte), .portClkOut(portClkOut), .portClkOeN(portClkOeN),
		.portDataOut(portDataOut), .portDataOeN(portDataOeN), .debugMode(debugMode),
		.cmdStart(cmdStart), .cmdEnd(cmdEnd), .rxByte(rxByte), .rxValid(rxValid),
		.rxErr(rxErr), .txErr(txErr), .txBusy(txBusy));
	twdl_device twdl_device_inst2(.link(link2.dev), .mclk(mclk), .rst(rst), .cmdDone(cmdDone2),
		.txLoad(txLoad2), .txByte(txByte2), .portClkOut(portClkOut), .portClkOeN(portClkOeN),
		.portDataOut(portDataOut), .portDataOeN(portDataOeN), .debugMode(debugMode2),
		.cmdStart(), .cmdEnd(), .rxByte(), .rxValid(), .rxErr(rxErr2), .txErr(txErr2),
		.txBusy());
	twdl_props twdl_props_inst(.mclk(mclk), .rst(rst), .hostClkOut(link.hostClkOut),
		.hostClkOeN(link.hostClkOeN), .hostDataOut(link.hostDataOut),
		.hostDataOeN(link.hostDataOeN), .devClkOut(link.devClkOut),
		.devClkOeN(link.devClkOeN), .devDataOut(link.devDataOut),
		.devDataOeN(link.devDataOeN), .debugSerialClock(link.debugSerialClock),
		.debugSerialData(link.debugSerialData));

	// clock and watchdog
	initial forever #2.5 mclk = ~mclk;
	initial begin
		#400000;
		mismatches++;
		test_done();
	end

	// shared pin function stirred at random while debug mode owns the pins
	always @(negedge mclk) if (rndOn) begin
		{portClkOut, portClkOeN, portDataOut, portDataOeN} = 4'($urandom);
	end

	// pulse counters and received bytes
	always @(negedge mclk) begin
		if (rxValid === 1'b1) rxQ.push_back(rxByte);
		nRx += (rxValid === 1'b1);
		nAck += (ackErr === 1'b1);
		nRd += (rdValid === 1'b1);
		nSt += (cmdStart === 1'b1);
		nEnd += (cmdEnd === 1'b1);
		nTxErr += (txErr === 1'b1);
		nRxErr2 += (rxErr2 === 1'b1);
		nTxErr2 += (txErr2 === 1'b1);
	end

	// ==========================================================
	// compare and closing tasks
	task automatic cmp1(input string nm, input logic e, input logic g);
		checked++;
		if (g !== e) begin
			mismatches++;
			$display("[ERR] %s expected %b seen %b", nm, e, g);
		end
	endtask
	task automatic cmp8(input string nm, input logic [7:0] e, input logic [7:0] g);
		checked++;
		if (g !== e) begin
			mismatches++;
			$display("[ERR] %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic test_done;
		if (mismatches == 0 && checked > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask

	// ==========================================================
	// host port and wait helpers
	task automatic host_op(input twdl_op_t k, input logic [7:0] v);
		int n;
		@(negedge mclk);
		opValid = 1'b1;
		opKind = k;
		opData = v;
		for (n = 0; n < 5000 && opReady !== 1'b1; n++) @(negedge mclk);
		cmp1("opReady", 1'b1, opReady);
		@(negedge mclk);
		opValid = 1'b0;
	endtask
	task automatic wait_until(ref int c, input int tgt);
		int n;
		for (n = 0; n < 5000 && c < tgt; n++) @(negedge mclk);
		cmp1("count reached", 1'b1, c >= tgt);
	endtask
	task automatic dev_load(input logic [7:0] v);
		@(negedge mclk);
		txByte = v;
		txLoad = 1'b1;
		@(negedge mclk);
		txLoad = 1'b0;
	endtask
	// stop, check the wait state, then let the device go
	task automatic host_end(input int ends);
		host_op(TWDL_OP_STOP, 8'h00);
		wait_until(nEnd, ends);
		repeat (100) @(negedge mclk);
		cmp1("clock in wait", 1'b0, link.debugSerialClock);
		cmp1("opReady in wait", 1'b0, opReady);
		cmp1("inCmd in wait", 1'b0, inCmd);
		cmdDone = 1'b1;
		@(negedge mclk);
		cmdDone = 1'b0;
		repeat (20) @(negedge mclk);
		cmp1("clock after done", 1'b1, link.debugSerialClock);
	endtask

	// ==========================================================
	// bench as host on the second link
	task automatic half;
		repeat (HALF_CYC) @(negedge mclk);
	endtask
	task automatic bb_rise;
		int n;
		link2.hostClkOeN = 1'b1;
		for (n = 0; n < 5000 && link2.debugSerialClock !== 1'b1; n++) @(negedge mclk);
		cmp1("clock2 released", 1'b1, link2.debugSerialClock);
	endtask
	task automatic bb_pkt(input logic [9:0] tx, output logic [9:0] rx);
		for (int i = 9; i >= 0; i--) begin
			link2.hostDataOeN = tx[i];
			half();
			bb_rise();
			repeat (HALF_CYC / 2) @(negedge mclk);
			rx[i] = link2.debugSerialData;
			half();
			link2.hostClkOeN = 1'b0;
			@(negedge mclk);
		end
	endtask
	task automatic bb_start;
		link2.hostDataOeN = 1'b0;
		half();
		link2.hostClkOeN = 1'b0;
		@(negedge mclk);
	endtask
	// data low under a low clock, clock up, then data up: the stop
	task automatic bb_stop;
		link2.hostDataOeN = 1'b0;
		half();
		bb_rise();
		half();
		link2.hostDataOeN = 1'b1;
		repeat (100) @(negedge mclk);
		cmp1("clock2 in wait", 1'b0, link2.debugSerialClock);
		cmdDone2 = 1'b1;
		@(negedge mclk);
		cmdDone2 = 1'b0;
		bb_rise();
		half();
	endtask

	// ==========================================================
	// main sequence
	initial begin
		void'($urandom(94));
		link2.hostClkOut = 1'b0;
		link2.hostDataOut = 1'b0;
		link2.hostClkOeN = 1'b0;
		link2.hostDataOeN = 1'b1;
		repeat (4) @(negedge mclk);
		rst = 1'b0;
		repeat (ENTRY_HOLD_CYC) @(negedge mclk);
		link2.hostClkOeN = 1'b1;
		repeat (100) @(negedge mclk);
		cmp1("debugMode", 1'b1, debugMode);
		cmp1("debugMode2", 1'b1, debugMode2);
		rndOn = 1'b1;
		// one write command of corner and random bytes
		wb = '{8'h80, 8'hff, 8'($urandom), 8'($urandom)};
		foreach (wb[i]) host_op(TWDL_OP_WRITE, wb[i]);
		host_end(1);
		foreach (wb[i]) cmp8("rxByte", wb[i], rxQ[i]);
		cmp8("rxValid count", 8'h04, 8'(nRx));
		cmp8("ackErr count", 8'h00, 8'(nAck));
		cmp8("cmdStart count", 8'h01, 8'(nSt));
		// read command of two packets, second loaded in the same cycle the first packet begins
		wb[0] = 8'h01;
		wb[1] = 8'($urandom);
		dev_load(wb[0]);
		for (int i = 0; i < 2; i++) begin
			host_op(TWDL_OP_READ, 8'h00);
			cmp1("inCmd", 1'b1, inCmd);
			if (i == 0) dev_load(wb[1]);
			wait_until(nRd, i + 1);
			cmp8("rdData", wb[i], rdData);
			cmp1("txBusy", i == 0, txBusy);
		end
		cmp8("txErr count", 8'h00, 8'(nTxErr));
		host_end(2);
		// second link: good and bad parity, then a refused read-back
		bb_start();
		d = 8'($urandom);
		bb_pkt({d, ^d, 1'b1}, bbRx);
		cmp1("ack good parity", 1'b0, bbRx[0]);
		bb_pkt({d, ~(^d), 1'b1}, bbRx);
		cmp1("ack bad parity", 1'b1, bbRx[0]);
		cmp8("rxErr2 count", 8'h01, 8'(nRxErr2));
		bb_stop();
		txByte2 = 8'($urandom);
		txLoad2 = 1'b1;
		@(negedge mclk);
		txLoad2 = 1'b0;
		bb_start();
		bb_pkt(10'h3ff, bbRx);
		cmp8("read-back bits", txByte2, bbRx[9:2]);
		cmp1("read-back parity", ^txByte2, bbRx[1]);
		cmp8("txErr2 count", 8'h01, 8'(nTxErr2));
		bb_stop();
		// second reset with idle lines on the second link: no entry there
		rndOn = 1'b0;
		@(negedge mclk);
		{portClkOut, portClkOeN, portDataOut, portDataOeN} = 4'hf;
		rst = 1'b1;
		repeat (4) @(negedge mclk);
		rst = 1'b0;
		repeat (ENTRY_HOLD_CYC + 100) @(negedge mclk);
		cmp1("debugMode2 no entry", 1'b0, debugMode2);
		cmp1("debugMode again", 1'b1, debugMode);
		test_done();
	end
endmodule // two_wire_debug_link_tb
